// [verilog/spx_pkg.sv]
// Purpose: Constants, field layout and state type of the serial exchange port
// Assumes: 250 MHz system clock, 32-bit AHB-Lite register access
// Notes:   Each register holds 8 bits in the low byte of one aligned word
package spx_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL   = 8'h00;
   localparam logic [7:0] OFS_STATUS    = 8'h04;
   localparam logic [7:0] OFS_DATA      = 8'h08;
   localparam logic [7:0] OFS_DIRECTION = 8'h0c;

   // ------------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------------
   localparam int CB_IRQ_EN   = 7;
   localparam int CB_PORT_EN  = 6;
   localparam int CB_OPEN_DRN = 5;
   localparam int CB_CTL_SEL  = 4;
   localparam int CB_IDLE_LVL = 3;
   localparam int CB_EDGE_SEL = 2;
   localparam int SB_DONE     = 7;
   localparam int SB_COLL     = 6;
   localparam int SB_FAULT    = 4;
   localparam int DB_SEL_LVL  = 0;
   localparam int DB_MISO     = 2;
   localparam int DB_MOSI     = 3;
   localparam int DB_SCK      = 4;
   localparam int DB_SEL      = 5;
   localparam logic [7:0] DIR_PORT_MASK   = 8'h3c;
   localparam logic [7:0] CONTROL_RESET   = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [2:0] LAST_BIT        = 3'h7;
   localparam logic [3:0] LAST_EDGE       = 4'hf;

   // ------------------------------------------------------------------
   // Serial clock rates and half-period counts
   // ------------------------------------------------------------------
   localparam int CLK_MHZ     = 250;
   localparam int RATE_KHZ_00 = 2000;
   localparam int RATE_KHZ_01 = 1000;
   localparam int RATE_KHZ_10 = 250;
   localparam int RATE_KHZ_11 = 125;
   localparam logic [10:0] HALF_00 = 11'(CLK_MHZ * 1000 / (2 * RATE_KHZ_00));
   localparam logic [10:0] HALF_01 = 11'(CLK_MHZ * 1000 / (2 * RATE_KHZ_01));
   localparam logic [10:0] HALF_10 = 11'(CLK_MHZ * 1000 / (2 * RATE_KHZ_10));
   localparam logic [10:0] HALF_11 = 11'(CLK_MHZ * 1000 / (2 * RATE_KHZ_11));

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic {ENG_IDLE, ENG_RUN} spx_eng_t;

   typedef struct packed {
      logic        dphA;
      logic        dphB;
      logic        aWrite;
      logic [7:0]  aAddr;
      logic [31:0] rdata;
      logic [7:0]  ctrl;
      logic [7:0]  dir;
      logic        doneFlag;
      logic        collFlag;
      logic        faultFlag;
      logic        armDone;
      logic        armColl;
      logic        armFault;
      spx_eng_t    eng;
      logic [7:0]  shiftReg;
      logic [7:0]  rxByte;
      logic        outBit;
      logic [2:0]  bitCnt;
      logic [3:0]  edgeCnt;
      logic [10:0] divCnt;
      logic        sckLevel;
      logic        selS1;
      logic        selS2;
      logic        sckS1;
      logic        sckS2;
      logic        sckS3;
      logic        misoS1;
      logic        misoS2;
      logic        mosiS1;
      logic        mosiS2;
   } spx_state_t;

endpackage

// [verilog/spx_port.sv]
// Purpose: Full duplex serial byte exchange port, controller or target, AHB-Lite registers
// Assumes: Single 250 MHz clock; serial pins are asynchronous and pass two flip-flops
// Notes:   Every bus transfer takes one wait state; flags clear by status read then access
//
// Summary of operation
// - Three flags in one status register
// - Interrupt when enabled and any flag set
// - Done flag set after every byte exchange
// - Done clears: status read, then data access
// - Data write during exchange sets collision flag
// - Collision leaves running exchange untouched
// - Collision clears: status read, then data access
// - Fault sets flag, drops outputs, controller, enable
// - Fault clears: status read, then control write
// - Controller data write starts exchange and clock
// - Target shifts preloaded byte out per exchange
// - Rate bits apply to controller; target takes clock
// - Enable bit turns port on or off; select drive ignores it
// - Select bit chooses controller or target role
// - Idle level and edge bits set clocking
// - Rates 2 MHz, 1 MHz, 250 kHz, 125 kHz
// - Clock idles at the idle level bit
// - Fault: controller, select input, low seen
// - Eight bits out and in; byte readable
`timescale 1ns/100ps

module spx_port (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        sckIn,
   output logic             sckOut,
   output logic             sckOe,
   input  wire logic        mosiIn,
   output logic             mosiOut,
   output logic             mosiOe,
   input  wire logic        misoIn,
   output logic             misoOut,
   output logic             misoOe,
   input  wire logic        selNIn,
   output logic             selNOut,
   output logic             selNOe,
   output logic             irq
);

   spx_pkg::spx_state_t state_ff;
   spx_pkg::spx_state_t nxt_state;

   logic       addrTake;
   logic       rdStatus;
   logic       dataAcc;
   logic       wrData;
   logic       wrCtrl;
   logic       wrDir;
   logic       portEn;
   logic       ctlMode;
   logic       busy;
   logic       tick;
   logic       edgeEvt;
   logic       leadEdge;
   logic       sampleEdge;
   logic       shiftEdge;
   logic       doneEvt;
   logic       collEvt;
   logic       faultEvt;
   logic       rxIn;
   logic [7:0] shifted;
   logic [7:0] statusByte;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   function automatic logic [10:0] halfCycles(input logic [1:0] rate);
      case (rate)
         2'h0:    halfCycles = spx_pkg::HALF_00;
         2'h1:    halfCycles = spx_pkg::HALF_01;
         2'h2:    halfCycles = spx_pkg::HALF_10;
         default: halfCycles = spx_pkg::HALF_11;
      endcase
   endfunction

   // Open-drain style drive only pulls low
   function automatic logic drives(input logic od, input logic val);
      drives = !od || !val;
   endfunction

   // ------------------------------------------------------------------
   // Access decode and event terms
   // ------------------------------------------------------------------
   assign addrTake   = hsel && htrans[1] && hready;
   assign rdStatus   = state_ff.dphA && !state_ff.aWrite && hit(state_ff.aAddr, spx_pkg::OFS_STATUS);
   assign dataAcc    = state_ff.dphA && hit(state_ff.aAddr, spx_pkg::OFS_DATA);
   assign wrData     = dataAcc && state_ff.aWrite;
   assign wrCtrl     = state_ff.dphA && state_ff.aWrite && hit(state_ff.aAddr, spx_pkg::OFS_CONTROL);
   assign wrDir      = state_ff.dphA && state_ff.aWrite && hit(state_ff.aAddr, spx_pkg::OFS_DIRECTION);
   assign portEn     = state_ff.ctrl[spx_pkg::CB_PORT_EN];
   assign ctlMode    = state_ff.ctrl[spx_pkg::CB_CTL_SEL];
   assign busy       = ctlMode ? (state_ff.eng == spx_pkg::ENG_RUN) : (state_ff.bitCnt != 3'h0);
   assign tick       = (state_ff.eng == spx_pkg::ENG_RUN) &&
                       (state_ff.divCnt == halfCycles(state_ff.ctrl[1:0]) - 11'h001);
   // Controller clocks itself; target follows the synchronised pin
   assign edgeEvt    = ctlMode ? tick
                               : (portEn && !state_ff.selS2 && (state_ff.sckS2 != state_ff.sckS3));
   assign leadEdge   = ctlMode ? (state_ff.sckLevel == state_ff.ctrl[spx_pkg::CB_IDLE_LVL])
                               : (state_ff.sckS3 == state_ff.ctrl[spx_pkg::CB_IDLE_LVL]);
   assign sampleEdge = edgeEvt && (leadEdge != state_ff.ctrl[spx_pkg::CB_EDGE_SEL]);
   assign shiftEdge  = edgeEvt && (leadEdge == state_ff.ctrl[spx_pkg::CB_EDGE_SEL]);
   assign rxIn       = ctlMode ? state_ff.misoS2 : state_ff.mosiS2;
   assign shifted    = {state_ff.shiftReg[6:0], rxIn};
   assign doneEvt    = sampleEdge && (state_ff.bitCnt == spx_pkg::LAST_BIT);
   assign collEvt    = wrData && busy;
   assign faultEvt   = portEn && ctlMode && !state_ff.dir[spx_pkg::DB_SEL] && !state_ff.selS2;

   always_comb begin
      statusByte = 8'h00;
      statusByte[spx_pkg::SB_DONE]  = state_ff.doneFlag;
      statusByte[spx_pkg::SB_COLL]  = state_ff.collFlag;
      statusByte[spx_pkg::SB_FAULT] = state_ff.faultFlag;
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;

      // Pin synchronisers
      nxt_state.selS1  = selNIn;
      nxt_state.selS2  = state_ff.selS1;
      nxt_state.sckS1  = sckIn;
      nxt_state.sckS2  = state_ff.sckS1;
      nxt_state.sckS3  = state_ff.sckS2;
      nxt_state.misoS1 = misoIn;
      nxt_state.misoS2 = state_ff.misoS1;
      nxt_state.mosiS1 = mosiIn;
      nxt_state.mosiS2 = state_ff.mosiS1;

      // Bus phases: address, wait cycle doing the access, ready cycle
      nxt_state.dphA = 1'b0;
      nxt_state.dphB = state_ff.dphA;
      if (addrTake) begin
         nxt_state.dphA   = 1'b1;
         nxt_state.aWrite = hwrite;
         nxt_state.aAddr  = haddr[7:0];
      end
      if (state_ff.dphA && !state_ff.aWrite) begin
         nxt_state.rdata = 32'h0000_0000;
         if (hit(state_ff.aAddr, spx_pkg::OFS_CONTROL)) begin
            nxt_state.rdata[7:0] = state_ff.ctrl;
         end
         if (hit(state_ff.aAddr, spx_pkg::OFS_STATUS)) begin
            nxt_state.rdata[7:0] = statusByte;
         end
         if (hit(state_ff.aAddr, spx_pkg::OFS_DATA)) begin
            nxt_state.rdata[7:0] = state_ff.rxByte;
         end
         if (hit(state_ff.aAddr, spx_pkg::OFS_DIRECTION)) begin
            nxt_state.rdata[7:0] = state_ff.dir;
         end
      end
      if (wrCtrl) begin
         nxt_state.ctrl = hwdata[7:0];
      end
      if (wrDir) begin
         nxt_state.dir = hwdata[7:0];
      end

      // Shift engine
      if (sampleEdge) begin
         nxt_state.shiftReg = shifted;
         nxt_state.bitCnt   = state_ff.bitCnt + 3'h1;
      end
      if (doneEvt) begin
         nxt_state.rxByte = shifted;
      end
      if (shiftEdge) begin
         nxt_state.outBit = state_ff.shiftReg[7];
      end
      case (state_ff.eng)
         spx_pkg::ENG_IDLE: begin
            nxt_state.divCnt  = 11'h000;
            nxt_state.edgeCnt = 4'h0;
         end
         spx_pkg::ENG_RUN: begin
            if (tick) begin
               nxt_state.divCnt   = 11'h000;
               nxt_state.sckLevel = !state_ff.sckLevel;
               nxt_state.edgeCnt  = state_ff.edgeCnt + 4'h1;
               if (state_ff.edgeCnt == spx_pkg::LAST_EDGE) begin
                  nxt_state.eng = spx_pkg::ENG_IDLE;
               end
            end else begin
               nxt_state.divCnt = state_ff.divCnt + 11'h001;
            end
         end
         default: nxt_state.eng = spx_pkg::ENG_IDLE;
      endcase
      // A write during an exchange is dropped so the byte in flight finishes
      if (wrData && !busy) begin
         nxt_state.shiftReg = hwdata[7:0];
         nxt_state.outBit   = hwdata[7];
         nxt_state.bitCnt   = 3'h0;
         if (ctlMode && portEn) begin
            nxt_state.eng     = spx_pkg::ENG_RUN;
            nxt_state.divCnt  = 11'h000;
            nxt_state.edgeCnt = 4'h0;
         end
      end
      // Target deselected mid-byte starts over at the next select
      if (!ctlMode && state_ff.selS2) begin
         nxt_state.bitCnt = 3'h0;
         nxt_state.outBit = state_ff.shiftReg[7];
      end
      if (!portEn) begin
         nxt_state.eng    = spx_pkg::ENG_IDLE;
         nxt_state.bitCnt = 3'h0;
      end

      // Mode fault response
      if (faultEvt) begin
         nxt_state.dir                      = state_ff.dir & ~spx_pkg::DIR_PORT_MASK;
         nxt_state.ctrl[spx_pkg::CB_CTL_SEL] = 1'b0;
         nxt_state.ctrl[spx_pkg::CB_PORT_EN] = 1'b0;
         nxt_state.eng                      = spx_pkg::ENG_IDLE;
         nxt_state.bitCnt                   = 3'h0;
      end
      if (nxt_state.eng == spx_pkg::ENG_IDLE) begin
         nxt_state.sckLevel = nxt_state.ctrl[spx_pkg::CB_IDLE_LVL];
      end

      // Flag clearing: status read arms, later access clears; setting wins
      if (rdStatus) begin
         nxt_state.armDone  = state_ff.doneFlag;
         nxt_state.armColl  = state_ff.collFlag;
         nxt_state.armFault = state_ff.faultFlag;
      end
      if (dataAcc) begin
         if (state_ff.armDone) begin
            nxt_state.doneFlag = 1'b0;
         end
         if (state_ff.armColl) begin
            nxt_state.collFlag = 1'b0;
         end
         nxt_state.armDone = 1'b0;
         nxt_state.armColl = 1'b0;
      end
      if (wrCtrl) begin
         if (state_ff.armFault) begin
            nxt_state.faultFlag = 1'b0;
         end
         nxt_state.armFault = 1'b0;
      end
      if (doneEvt) begin
         nxt_state.doneFlag = 1'b1;
      end
      if (collEvt) begin
         nxt_state.collFlag = 1'b1;
      end
      if (faultEvt) begin
         nxt_state.faultFlag = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff      <= '0;
         state_ff.ctrl <= spx_pkg::CONTROL_RESET;
         state_ff.dir  <= spx_pkg::DIRECTION_RESET;
         state_ff.eng  <= spx_pkg::ENG_IDLE;
         state_ff.selS1 <= 1'b1;
         state_ff.selS2 <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   assign hreadyout = !state_ff.dphA;
   assign hresp     = 1'b0;
   assign hrdata    = state_ff.rdata;
   assign irq       = state_ff.ctrl[spx_pkg::CB_IRQ_EN] &&
                      (state_ff.doneFlag || state_ff.collFlag || state_ff.faultFlag);
   assign sckOut    = state_ff.sckLevel;
   assign mosiOut   = state_ff.outBit;
   assign misoOut   = state_ff.outBit;
   assign selNOut   = state_ff.dir[spx_pkg::DB_SEL_LVL];
   assign sckOe     = portEn && ctlMode && state_ff.dir[spx_pkg::DB_SCK] &&
                      drives(state_ff.ctrl[spx_pkg::CB_OPEN_DRN], state_ff.sckLevel);
   assign mosiOe    = portEn && ctlMode && state_ff.dir[spx_pkg::DB_MOSI] &&
                      drives(state_ff.ctrl[spx_pkg::CB_OPEN_DRN], state_ff.outBit);
   assign misoOe    = portEn && !ctlMode && !state_ff.selS2 && state_ff.dir[spx_pkg::DB_MISO] &&
                      drives(state_ff.ctrl[spx_pkg::CB_OPEN_DRN], state_ff.outBit);
   // Target mode always treats the select pin as an input
   assign selNOe    = ctlMode && state_ff.dir[spx_pkg::DB_SEL] &&
                      drives(state_ff.ctrl[spx_pkg::CB_OPEN_DRN], state_ff.dir[spx_pkg::DB_SEL_LVL]);

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence doneArmedAccess;
      state_ff.armDone && dataAcc && !doneEvt;
   endsequence

   sequence faultStatusRead;
      rdStatus && state_ff.faultFlag && !faultEvt;
   endsequence

   sequence faultCtrlWrite;
      wrCtrl && !faultEvt;
   endsequence

   irq_on_flag_a: assert property ($rose(state_ff.doneFlag) && state_ff.ctrl[spx_pkg::CB_IRQ_EN] |-> irq)
      else $error("interrupt not raised on done flag");
   done_sets_a: assert property (doneEvt |=> state_ff.doneFlag && (state_ff.bitCnt == 3'h0))
      else $error("done flag not set after eighth bit");
   done_clear_a: assert property (doneArmedAccess |=> !state_ff.doneFlag)
      else $error("done flag not cleared by armed data access");
   unarmed_keep_a: assert property (!state_ff.armDone && state_ff.doneFlag && dataAcc |=> state_ff.doneFlag)
      else $error("done flag cleared without status read");
   coll_set_a: assert property (wrData && busy |=> state_ff.collFlag)
      else $error("collision flag not set");
   coll_keep_a: assert property (wrData && busy && ctlMode && !tick && !faultEvt
                                 |=> state_ff.eng == spx_pkg::ENG_RUN && $stable(state_ff.edgeCnt))
      else $error("exchange disturbed by collision write");
   fault_resp_a: assert property (faultEvt |=> state_ff.faultFlag && !portEn && !ctlMode &&
                                  ((state_ff.dir & spx_pkg::DIR_PORT_MASK) == 8'h00) && !sckOe && !mosiOe)
      else $error("mode fault response incomplete");
   // A control write follows a status read no sooner than two cycles later
   fault_clear_a: assert property (faultStatusRead ##[2:4] faultCtrlWrite |=> !state_ff.faultFlag)
      else $error("fault flag not cleared by status read then control write");
   start_run_a: assert property (wrData && !busy && ctlMode && portEn && !faultEvt
                                 |=> state_ff.eng == spx_pkg::ENG_RUN ##1 state_ff.divCnt == 11'h001)
      else $error("controller write did not start exchange");
   rate_fast_a: assert property (state_ff.eng == spx_pkg::ENG_RUN && state_ff.ctrl[1:0] == 2'h0
                                 |-> state_ff.divCnt < spx_pkg::HALF_00)
      else $error("half period exceeds fastest rate");
   idle_level_a: assert property (state_ff.eng == spx_pkg::ENG_IDLE && $stable(state_ff.ctrl)
                                  |-> sckOut == state_ff.ctrl[spx_pkg::CB_IDLE_LVL])
      else $error("serial clock not at idle level");

endmodule // spx_port

// [tb/spx_far_target.sv]
// Purpose: Behavioural serial target facing the port in controller role
// Assumes: Polarity and phase come from the bench and match the port
// Notes:   A deselected data line shows the inverse of its last value
`timescale 1ns/100ps

module spx_far_target (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       selN,
   input  wire logic       pol,
   input  wire logic       pha,
   input  wire logic [7:0] txByte,
   output logic            miso,
   output logic [7:0]      rxByte
);
   logic [7:0] rxSh;
   logic [2:0] cnt;
   logic [2:0] outIdx;

   initial begin
      miso = 1'b0;
      rxByte = 8'h00;
      rxSh = 8'h00;
      cnt = 3'h0;
      outIdx = 3'h0;
   end

   always @(negedge selN) begin
      cnt = 3'h0;
      outIdx = 3'h0;
   end

   // Sample on one clock edge, present the next bit on the other
   always @(sck) begin
      if (selN === 1'b0) begin
         if ((sck !== pol) != pha) begin
            rxSh = {rxSh[6:0], mosi};
            cnt = cnt + 3'h1;
            if (cnt == 3'h0)
               rxByte = rxSh;
         end else begin
            outIdx = cnt;
         end
      end
   end

   always @(selN or outIdx) begin
      if (selN === 1'b0)
         miso = txByte[3'h7 - outIdx];
      else
         miso = ~miso;
   end
endmodule // spx_far_target

// [tb/test_spi_status_and_transfer_logic.sv]
// Purpose: Register-level test of the serial exchange port with a target model
// Assumes: Single AHB-Lite slave, so hready is the port's hreadyout
// Notes:   Rate check measures the first half period of the serial clock
`timescale 1ns/100ps

module test_spi_status_and_transfer_logic;
   localparam logic [7:0] CTL = spx_pkg::OFS_CONTROL;
   localparam logic [7:0] STA = spx_pkg::OFS_STATUS;
   localparam logic [7:0] DAT = spx_pkg::OFS_DATA;
   localparam logic [7:0] DIR = spx_pkg::OFS_DIRECTION;
   localparam int KHZ [4] = '{2000, 1000, 250, 125};
   logic        clk, rst, hsel, hwrite, hready, hresp, irq;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic        sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selNOut, selNOe;
   logic        tbSck, tbMosi, selLow, pol, pha, tgtMiso;
   logic [7:0]  tgtRx, got;
   int          n;
   int          failures = 0;
   int          n_compared = 0;
   // Pin levels: pull-up on select unless the bench pulls it low
   wire sckW  = sckOe ? sckOut : tbSck;
   wire mosiW = mosiOe ? mosiOut : tbMosi;
   wire misoW = misoOe ? misoOut : tgtMiso;
   wire selW  = selNOe ? selNOut : !selLow;

   spx_port spx_port_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
      .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe),
      .misoIn(misoW), .misoOut(misoOut), .misoOe(misoOe), .selNIn(selW), .selNOut(selNOut), .selNOe(selNOe),
      .irq(irq));
   spx_far_target spx_far_target_i (.sck(sckW), .mosi(mosiW), .selN(selW), .pol(pol), .pha(pha),
      .txByte(8'h96), .miso(tgtMiso), .rxByte(tgtRx));

   task automatic close_out();
      if (failures == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic waitRdy();
      @(negedge clk);
      while (hready !== 1'b1) @(negedge clk);
   endtask

   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      waitRdy();
      @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      waitRdy();
      r = hrdata;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 8'h00, r);
      chk(r, {24'h0, e});
   endtask

   task automatic waitFlag(input int b, input logic [7:0] e);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < 6000 && r[b] !== 1'b1; i++)
         xfer(1'b0, STA, 8'h00, r);
      chk(r, {24'h0, e});
   endtask

   task automatic pins(input logic [5:0] e);
      @(negedge clk);
      chk({irq, sckOut, sckOe, mosiOe, misoOe, selNOe}, {26'h0, e});
      @(posedge clk);
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial begin
      #400000;
      failures++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {tbSck, tbMosi, selLow, pol, pha} = '0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc(CTL, 8'h00);
      rdc(STA, 8'h00);
      rdc(DIR, 8'h00);
      rdc(8'h10, 8'h00);
      pins(6'h00);
      wr(DIR, 8'h38);
      wr(CTL, 8'h10);
      wr(DAT, 8'h11);
      repeat (300) @(posedge clk);
      rdc(STA, 8'h00);
      pins(6'h01);
      for (int m = 0; m < 4; m++) begin
         pol <= m[1];
         pha <= m[0];
         wr(DIR, 8'h39);
         wr(CTL, {4'hd, m[1:0], m[1:0]});
         wr(DIR, 8'h38);
         pins({1'b0, m[1], 4'hd});
         wr(DAT, 8'ha5 ^ m[7:0]);
         wr(DAT, 8'h3c);
         @(negedge clk);
         while (sckOut === m[1]) @(negedge clk);
         n = 0;
         while (sckOut !== m[1]) begin
            n++;
            @(negedge clk);
         end
         @(posedge clk);
         chk(n, 250000 / (2 * KHZ[m]));
         waitFlag(spx_pkg::SB_DONE, 8'hc0);
         repeat (1100) @(posedge clk);
         pins({1'b1, m[1], 4'hd});
         rdc(DAT, 8'h96);
         chk(tgtRx, 8'ha5 ^ m[7:0]);
         rdc(STA, 8'h00);
      end
      wr(DIR, 8'h1c);
      wr(CTL, 8'hd0);
      selLow <= 1'b1;
      repeat (10) @(posedge clk);
      selLow <= 1'b0;
      rdc(CTL, 8'h80);
      rdc(DIR, 8'h00);
      pins(6'h20);
      wr(CTL, 8'h80);
      pins(6'h20);
      rdc(STA, 8'h10);
      wr(DAT, 8'h00);
      rdc(STA, 8'h10);
      wr(CTL, 8'h00);
      rdc(STA, 8'h00);
      wr(DIR, 8'h04);
      wr(CTL, 8'h40);
      wr(DAT, 8'h5a);
      selLow <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 7; i >= 0; i--) begin
         tbMosi <= i[0] ^ i[1];
         repeat (6) @(posedge clk);
         got[i] = misoW;
         tbSck <= 1'b1;
         repeat (6) @(posedge clk);
         tbSck <= 1'b0;
      end
      repeat (6) @(posedge clk);
      selLow <= 1'b0;
      chk(got, 8'h5a);
      waitFlag(spx_pkg::SB_DONE, 8'h80);
      rdc(DAT, 8'h66);
      rdc(STA, 8'h00);
      close_out();
   end
endmodule // test_spi_status_and_transfer_logic
